// >>> ppc_pkg.sv
// Purpose: Shared constants and types for the port performance counter pair
// Assumes: 32-bit AXI4-Lite register access, one core clock
// Notes:   Offsets are byte addresses; each register is one aligned word
package ppc_pkg;

	// Register map
	localparam logic [7:0] OFS_CTRL0    = 8'he0;
	localparam logic [7:0] OFS_CMP0     = 8'he4;
	localparam logic [7:0] OFS_DATA0    = 8'he8;
	localparam logic [7:0] OFS_CTRL1    = 8'hf0;
	localparam logic [7:0] OFS_CMP1     = 8'hf4;
	localparam logic [7:0] OFS_DATA1    = 8'hf8;
	localparam logic [7:0] OFS_IRQ_STS  = 8'hd0;
	localparam logic [7:0] OFS_IRQ_MASK = 8'hd4;

	// Response/control field positions
	localparam int CTRL_EN_BIT    = 0;
	localparam int OVF_STS_BIT    = 12;
	localparam int CMP_STS_BIT    = 13;
	localparam int OUT_GLOBAL_BIT = 14;
	localparam int OUT_PIN_BIT    = 15;
	localparam int RSEL_LSB       = 19;
	localparam int MODE_LSB       = 22;
	localparam int OVF_BIT        = 31;
	localparam int COUNT_W        = 31;
	localparam int IRQ_W          = 4;

	// Writable bits of the response/control word; 31:26 reserved
	localparam logic [31:0] CTRL_WMASK  = 32'h03f8c001;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
	localparam logic [31:0] CMP_RESET   = 32'hffff_ffff;
	localparam logic [31:0] DATA_RESET  = 32'h0000_0000;
	localparam logic [30:0] COUNT_ONE   = 31'h0000_0001;

	// Reset-event selection codes; bit 2 set picks an event pin
	localparam logic [2:0] RSEL_NONE    = 3'h0;
	localparam logic [2:0] RSEL_PSTS    = 3'h1;
	localparam logic [2:0] RSEL_PMATCH  = 3'h2;
	localparam int         RSEL_PIN_BIT = 2;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		CMP_OFF,
		CMP_THRESH,
		CMP_MAX,
		CMP_ADDR
	} ppc_cmp_mode_t;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] cmp;
		logic [31:0] data;
		logic        cmp_sts;
		logic        preload;
		logic        sts_prev;
	} ppc_ctr_t;

	typedef struct packed {
		ppc_ctr_t [1:0]   ctr;
		logic [IRQ_W-1:0] irq_sts;
		logic [IRQ_W-1:0] irq_mask;
		logic             aw_full;
		logic [7:0]       aw_addr;
		logic             w_full;
		logic [31:0]      wdata;
		logic [3:0]       wstrb;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
		logic [1:0]       pin_out;
		logic [1:0]       glob_out;
	} ppc_state_t;

endpackage

// >>> ppc_counter_pair.sv
// Purpose: Pair of performance counters with compare, capture and range logic
// Assumes: Event, address and sample inputs are synchronous to CLK
// Notes:   All state lives in one struct; three comb blocks, one register block
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Operation
// - A write of one to the overflow status bit clears overflow and leaves the count intact.
// - A sample start zeroes the counter unless software preloaded it since the last sample.
// - In threshold mode each increment compares count to compare and sets status when greater.
// - In capture mode the compare register is overwritten on each increment that takes the count above it.
// - Comparisons use the overflow bit as the top bit of the count.
// - In address mode either counter needs address above counter 0's compare and at or below counter 1's.
// - The address compared is request address bits 31 down to 0.
// - The response register steers its counter and shows overflow and compare status.
// - Compare mode 00 off, 01 threshold, 10 capture, 11 address range.
// - Reset select clears count and status on none, partner status, partner match or a pin.
module ppc_counter_pair (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	input  wire logic [1:0]  EVENT_IN,
	input  wire logic        ADDR_VALID,
	input  wire logic [31:0] REQ_ADDR,
	input  wire logic        SAMPLE_START,
	input  wire logic [3:0]  EVENT_PINS_IN,
	output logic [1:0]       EVENT_PINS_OUT,
	output logic [1:0]       GLOBAL_STATUS,
	output logic             IRQ
);

	ppc_pkg::ppc_state_t    s_ff;
	ppc_pkg::ppc_state_t    nxt_s;
	ppc_pkg::ppc_cmp_mode_t mode [2];
	logic                   wr_go;
	logic                   rd_go;
	logic                   range_ok;
	logic [1:0]             qual;
	logic [1:0]             inc;
	logic [1:0]             rst_hit;
	logic [1:0]             evt_sts;
	logic [1:0]             sw_ctrl;
	logic [1:0]             sw_cmp;
	logic [1:0]             sw_data;
	logic [1:0]             cnt_quiet;
	logic [31:0]            rd_val;
	logic [1:0]             rd_resp;

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] wmerge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  strb
	);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Control word as software sees it, with live status bits
	function automatic logic [31:0] ctrl_view(input ppc_pkg::ppc_ctr_t c);
		logic [31:0] r;
		r = c.ctrl & ppc_pkg::CTRL_WMASK;
		r[ppc_pkg::OVF_STS_BIT] = c.data[ppc_pkg::OVF_BIT];
		r[ppc_pkg::CMP_STS_BIT] = c.cmp_sts;
		return r;
	endfunction

	// Handshake outputs are combinational; one write and one read in flight
	assign S_AXI_AWREADY  = !s_ff.aw_full && !s_ff.bvalid;
	assign S_AXI_WREADY   = !s_ff.w_full && !s_ff.bvalid;
	assign S_AXI_ARREADY  = !s_ff.rvalid;
	assign S_AXI_BVALID   = s_ff.bvalid;
	assign S_AXI_BRESP    = s_ff.bresp;
	assign S_AXI_RVALID   = s_ff.rvalid;
	assign S_AXI_RDATA    = s_ff.rdata;
	assign S_AXI_RRESP    = s_ff.rresp;
	assign EVENT_PINS_OUT = s_ff.pin_out;
	assign GLOBAL_STATUS  = s_ff.glob_out;
	assign IRQ            = |(s_ff.irq_sts & s_ff.irq_mask);

	// Register read mux
	always_comb begin
		rd_val  = 32'h0000_0000;
		rd_resp = ppc_pkg::RESP_OKAY;
		unique case (S_AXI_ARADDR)
			ppc_pkg::OFS_CTRL0:    rd_val = ctrl_view(s_ff.ctr[0]);
			ppc_pkg::OFS_CMP0:     rd_val = s_ff.ctr[0].cmp;
			ppc_pkg::OFS_DATA0:    rd_val = s_ff.ctr[0].data;
			ppc_pkg::OFS_CTRL1:    rd_val = ctrl_view(s_ff.ctr[1]);
			ppc_pkg::OFS_CMP1:     rd_val = s_ff.ctr[1].cmp;
			ppc_pkg::OFS_DATA1:    rd_val = s_ff.ctr[1].data;
			ppc_pkg::OFS_IRQ_STS:  rd_val = {28'h000_0000, s_ff.irq_sts};
			ppc_pkg::OFS_IRQ_MASK: rd_val = {28'h000_0000, s_ff.irq_mask};
			default:               rd_resp = ppc_pkg::RESP_DECERR;
		endcase
	end

	// Event qualification, shared by both counters
	always_comb begin
		range_ok = (REQ_ADDR > s_ff.ctr[0].cmp) && (REQ_ADDR <= s_ff.ctr[1].cmp);
		for (int i = 0; i < 2; i++) begin
			mode[i]    = ppc_pkg::ppc_cmp_mode_t'(s_ff.ctr[i].ctrl[ppc_pkg::MODE_LSB +: 2]);
			evt_sts[i] = s_ff.ctr[i].data[ppc_pkg::OVF_BIT] || s_ff.ctr[i].cmp_sts;
			// Range gate only applies to a counter set to address mode
			qual[i]    = EVENT_IN[i]
				&& (mode[i] != ppc_pkg::CMP_ADDR || (ADDR_VALID && range_ok));
			inc[i]     = qual[i] && s_ff.ctr[i].ctrl[ppc_pkg::CTRL_EN_BIT];
		end
	end

	// Next-state logic
	always_comb begin
		logic [31:0] d;
		logic [31:0] c;
		logic [31:0] cc;
		logic [2:0]  rsel;
		logic        cs;
		logic        ovf_new;
		logic        cmp_new;
		logic [ppc_pkg::IRQ_W-1:0] irq_new;
		logic [ppc_pkg::IRQ_W-1:0] irq_clr;
		logic [31:0] mw;
		d       = 32'h0000_0000;
		c       = 32'h0000_0000;
		cc      = 32'h0000_0000;
		rsel    = ppc_pkg::RSEL_NONE;
		cs      = 1'b0;
		ovf_new = 1'b0;
		cmp_new = 1'b0;
		irq_new = '0;
		irq_clr = '0;
		mw      = 32'h0000_0000;
		nxt_s   = s_ff;
		wr_go   = s_ff.aw_full && s_ff.w_full && !s_ff.bvalid;
		rd_go   = S_AXI_ARVALID && !s_ff.rvalid;

		// Write channel capture, address and data in either order
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			nxt_s.aw_full = 1'b1;
			nxt_s.aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			nxt_s.w_full = 1'b1;
			nxt_s.wdata  = S_AXI_WDATA;
			nxt_s.wstrb  = S_AXI_WSTRB;
		end
		if (s_ff.bvalid && S_AXI_BREADY) begin
			nxt_s.bvalid = 1'b0;
		end
		if (wr_go) begin
			nxt_s.aw_full = 1'b0;
			nxt_s.w_full  = 1'b0;
			nxt_s.bvalid  = 1'b1;
			nxt_s.bresp   = ppc_pkg::RESP_OKAY;
		end

		for (int i = 0; i < 2; i++) begin
			sw_ctrl[i] = wr_go && s_ff.aw_addr == (i == 0 ? ppc_pkg::OFS_CTRL0 : ppc_pkg::OFS_CTRL1);
			sw_cmp[i]  = wr_go && s_ff.aw_addr == (i == 0 ? ppc_pkg::OFS_CMP0 : ppc_pkg::OFS_CMP1);
			sw_data[i] = wr_go && s_ff.aw_addr == (i == 0 ? ppc_pkg::OFS_DATA0 : ppc_pkg::OFS_DATA1);
		end
		if (wr_go && !(|sw_ctrl) && !(|sw_cmp) && !(|sw_data)) begin
			if (s_ff.aw_addr == ppc_pkg::OFS_IRQ_MASK) begin
				// Only the low mask bits exist; the rest of the word is dropped
				mw             = wmerge({28'h000_0000, s_ff.irq_mask}, s_ff.wdata, s_ff.wstrb);
				nxt_s.irq_mask = mw[ppc_pkg::IRQ_W-1:0];
			end else if (s_ff.aw_addr != ppc_pkg::OFS_IRQ_STS) begin
				nxt_s.bresp = ppc_pkg::RESP_DECERR;
			end
		end

		// Counters
		for (int i = 0; i < 2; i++) begin
			d       = s_ff.ctr[i].data;
			c       = s_ff.ctr[i].cmp;
			cs      = s_ff.ctr[i].cmp_sts;
			ovf_new = 1'b0;
			cmp_new = 1'b0;
			rsel    = s_ff.ctr[i].ctrl[ppc_pkg::RSEL_LSB +: 3];
			// Partner status is taken on its rising edge so a held flag resets once
			if (rsel[ppc_pkg::RSEL_PIN_BIT]) begin
				rst_hit[i] = EVENT_PINS_IN[rsel[1:0]];
			end else if (rsel == ppc_pkg::RSEL_PSTS) begin
				rst_hit[i] = evt_sts[1-i] && !s_ff.ctr[1-i].sts_prev;
			end else if (rsel == ppc_pkg::RSEL_PMATCH) begin
				rst_hit[i] = qual[1-i];
			end else begin
				rst_hit[i] = 1'b0;
			end
			cnt_quiet[i] = !rst_hit[i] && !SAMPLE_START && !sw_data[i];

			if (rst_hit[i]) begin
				d  = ppc_pkg::DATA_RESET;
				cs = 1'b0;
			end else if (SAMPLE_START) begin
				if (!s_ff.ctr[i].preload) begin
					d = ppc_pkg::DATA_RESET;
				end
			end else if (inc[i]) begin
				{ovf_new, d[ppc_pkg::COUNT_W-1:0]} = {1'b0, d[ppc_pkg::COUNT_W-1:0]}
					+ {1'b0, ppc_pkg::COUNT_ONE};
				ovf_new = ovf_new && !d[ppc_pkg::OVF_BIT];
				if (ovf_new) begin
					d[ppc_pkg::OVF_BIT] = 1'b1;
				end
				// Overflow bit is the MSB of the magnitude compare
				if (d > c) begin
					if (mode[i] == ppc_pkg::CMP_THRESH) begin
						cmp_new = !cs;
						cs      = 1'b1;
					end else if (mode[i] == ppc_pkg::CMP_MAX) begin
						c = d;
					end
				end
			end
			if (SAMPLE_START) begin
				nxt_s.ctr[i].preload = 1'b0;
			end

			// Software stores; hardware sets of status still win over a clear
			if (sw_data[i]) begin
				d = wmerge(d, s_ff.wdata, s_ff.wstrb);
				nxt_s.ctr[i].preload = 1'b1;
			end
			if (sw_cmp[i]) begin
				c = wmerge(c, s_ff.wdata, s_ff.wstrb);
			end
			if (sw_ctrl[i]) begin
				cc = wmerge(s_ff.ctr[i].ctrl, s_ff.wdata, s_ff.wstrb);
				nxt_s.ctr[i].ctrl = cc & ppc_pkg::CTRL_WMASK;
				if (s_ff.wstrb[1] && s_ff.wdata[ppc_pkg::OVF_STS_BIT] && !ovf_new) begin
					d[ppc_pkg::OVF_BIT] = 1'b0;
				end
				if (s_ff.wstrb[1] && s_ff.wdata[ppc_pkg::CMP_STS_BIT] && !cmp_new) begin
					cs = 1'b0;
				end
			end

			nxt_s.ctr[i].data     = d;
			nxt_s.ctr[i].cmp      = c;
			nxt_s.ctr[i].cmp_sts  = cs;
			nxt_s.ctr[i].sts_prev = evt_sts[i];
			nxt_s.pin_out[i]  = (d[ppc_pkg::OVF_BIT] || cs)
				&& nxt_s.ctr[i].ctrl[ppc_pkg::OUT_PIN_BIT];
			nxt_s.glob_out[i] = (d[ppc_pkg::OVF_BIT] || cs)
				&& nxt_s.ctr[i].ctrl[ppc_pkg::OUT_GLOBAL_BIT];
			irq_new[2*i]   = ovf_new;
			irq_new[2*i+1] = cmp_new;
		end

		// Read answer; reading the interrupt status clears it
		if (s_ff.rvalid && S_AXI_RREADY) begin
			nxt_s.rvalid = 1'b0;
		end
		if (rd_go) begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rdata  = rd_val;
			nxt_s.rresp  = rd_resp;
			if (S_AXI_ARADDR == ppc_pkg::OFS_IRQ_STS) begin
				irq_clr = '1;
			end
		end
		nxt_s.irq_sts = (s_ff.irq_sts & ~irq_clr) | irq_new;
	end

	// State register, synchronous reset
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			s_ff            <= '0;
			s_ff.ctr[0].cmp <= ppc_pkg::CMP_RESET;
			s_ff.ctr[1].cmp <= ppc_pkg::CMP_RESET;
		end else begin
			s_ff <= nxt_s;
		end
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	sequence s_inc0_calm;
		inc[0] && cnt_quiet[0] && !sw_ctrl[0] && !sw_cmp[0];
	endsequence

	sequence s_thr_armed;
		mode[0] == ppc_pkg::CMP_THRESH ##0 s_inc0_calm;
	endsequence

	chk_ovf_clear_keeps: assert property (
		sw_ctrl[0] && s_ff.wstrb[1] && s_ff.wdata[ppc_pkg::OVF_STS_BIT] && !inc[0]
		&& cnt_quiet[0] |=> !s_ff.ctr[0].data[31]
		&& s_ff.ctr[0].data[30:0] == $past(s_ff.ctr[0].data[30:0]))
		else $error("overflow clear disturbed the count");

	chk_sample_zeroes: assert property (
		SAMPLE_START && !s_ff.ctr[0].preload && !rst_hit[0] && !sw_data[0]
		|=> s_ff.ctr[0].data == 32'h0000_0000)
		else $error("sample start did not zero counter");

	chk_preload_kept: assert property (
		SAMPLE_START && s_ff.ctr[0].preload && !rst_hit[0] && !sw_data[0]
		|=> s_ff.ctr[0].data == $past(s_ff.ctr[0].data) && !s_ff.ctr[0].preload)
		else $error("preloaded count lost at sample start");

	chk_thresh_status: assert property (
		s_thr_armed ##0 (s_ff.ctr[0].data >= s_ff.ctr[0].cmp)
		##0 !(&s_ff.ctr[0].data[30:0]) |=> s_ff.ctr[0].cmp_sts)
		else $error("threshold status not set");

	chk_max_capture: assert property (
		mode[0] == ppc_pkg::CMP_MAX ##0 s_inc0_calm
		|=> s_ff.ctr[0].cmp >= s_ff.ctr[0].data)
		else $error("compare register did not track max");

	chk_ovf_in_compare: assert property (
		s_thr_armed ##0 s_ff.ctr[0].data[31] && !s_ff.ctr[0].cmp[31]
		|=> s_ff.ctr[0].cmp_sts)
		else $error("overflow bit ignored in compare");

	chk_addr_gate: assert property (
		mode[0] == ppc_pkg::CMP_ADDR && EVENT_IN[0] && !range_ok && cnt_quiet[0]
		&& !sw_ctrl[0] |=> $stable(s_ff.ctr[0].data))
		else $error("out-of-range address counted");

	chk_ctrl_readback: assert property (
		rd_go && S_AXI_ARADDR == ppc_pkg::OFS_CTRL0
		|=> S_AXI_RVALID && S_AXI_RDATA[ppc_pkg::OVF_STS_BIT] == $past(s_ff.ctr[0].data[31]))
		else $error("response register shows wrong overflow");

	chk_reset_event: assert property (
		rst_hit[0] && !sw_data[0] && !sw_ctrl[0]
		|=> s_ff.ctr[0].data == 32'h0000_0000 && !s_ff.ctr[0].cmp_sts)
		else $error("reset event did not clear counter");

	chk_count_wrap: assert property (
		s_inc0_calm ##0 (&s_ff.ctr[0].data[30:0])
		|=> s_ff.ctr[0].data[31] && s_ff.ctr[0].data[30:0] == 31'h0000_0000)
		else $error("wrap did not set overflow");

	chk_write_answer: assert property (
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
		|-> ##[1:2] S_AXI_BVALID)
		else $error("write response late");

endmodule // ppc_counter_pair

// >>> port_perf_counter_pair_bench.sv
// Purpose: Self-checking bench for the port performance counter pair
// Assumes: Bench masters AXI4-Lite; ready signals sampled at negedge
// Notes:   One task per scenario; bready and rready stay high throughout
`timescale 1ns/1ps
module port_perf_counter_pair_bench;
	logic        clk;
	logic        rst_n;
	logic [7:0]  s_awaddr;
	logic        s_awvalid;
	logic        s_awready;
	logic [31:0] s_wdata;
	logic        s_wvalid;
	logic        s_wready;
	logic [1:0]  s_bresp;
	logic        s_bvalid;
	logic [7:0]  s_araddr;
	logic        s_arvalid;
	logic        s_arready;
	logic [31:0] s_rdata;
	logic [1:0]  s_rresp;
	logic        s_rvalid;
	logic [1:0]  ev_in;
	logic        addr_valid;
	logic [31:0] req_addr;
	logic        sample_start;
	logic [3:0]  pins_in;
	logic [1:0]  pins_out;
	logic [1:0]  glob_sts;
	logic        irq;
	int          error_cnt;
	int          comparisons;
	logic [31:0] rd_d;
	logic [1:0]  rd_r;

	ppc_counter_pair ppc_counter_pair_inst (
		.CLK(clk), .RST_N(rst_n),
		.S_AXI_AWADDR(s_awaddr), .S_AXI_AWVALID(s_awvalid), .S_AXI_AWREADY(s_awready),
		.S_AXI_WDATA(s_wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(s_wvalid),
		.S_AXI_WREADY(s_wready), .S_AXI_BRESP(s_bresp), .S_AXI_BVALID(s_bvalid),
		.S_AXI_BREADY(1'b1), .S_AXI_ARADDR(s_araddr), .S_AXI_ARVALID(s_arvalid),
		.S_AXI_ARREADY(s_arready), .S_AXI_RDATA(s_rdata), .S_AXI_RRESP(s_rresp),
		.S_AXI_RVALID(s_rvalid), .S_AXI_RREADY(1'b1), .EVENT_IN(ev_in),
		.ADDR_VALID(addr_valid), .REQ_ADDR(req_addr), .SAMPLE_START(sample_start),
		.EVENT_PINS_IN(pins_in), .EVENT_PINS_OUT(pins_out), .GLOBAL_STATUS(glob_sts),
		.IRQ(irq)
	);

	// Free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	// Handshakes judged at negedge, where inputs are quiet until the next edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_hs;
		logic w_hs;
		logic b_hs;
		b_hs = 1'b0;
		s_awaddr  <= a;
		s_wdata   <= d;
		s_awvalid <= 1'b1;
		s_wvalid  <= 1'b1;
		while (!b_hs) begin
			@(negedge clk);
			aw_hs = s_awvalid & s_awready;
			w_hs  = s_wvalid & s_wready;
			b_hs  = s_bvalid;
			r     = s_bresp;
			@(posedge clk);
			if (aw_hs) s_awvalid <= 1'b0;
			if (w_hs) s_wvalid <= 1'b0;
		end
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_hs;
		logic r_hs;
		r_hs = 1'b0;
		s_araddr  <= a;
		s_arvalid <= 1'b1;
		while (!r_hs) begin
			@(negedge clk);
			ar_hs = s_arvalid & s_arready;
			r_hs  = s_rvalid;
			d     = s_rdata;
			r     = s_rresp;
			@(posedge clk);
			if (ar_hs) s_arvalid <= 1'b0;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
		axi_rd(a, rd_d, rd_r);
		check(rd_d, exp, msg);
	endtask

	// Event burst of n cycles, then two edges so status outputs settle
	task automatic ev(input logic [1:0] m, input int n);
		ev_in <= m;
		repeat (n) @(posedge clk);
		ev_in <= 2'b00;
		repeat (2) @(posedge clk);
	endtask

	task automatic t_reset();
		rd_chk(ppc_pkg::OFS_CMP0, 32'hffff_ffff, "cmp0 reset");
		rd_chk(ppc_pkg::OFS_CMP1, 32'hffff_ffff, "cmp1 reset");
		rd_chk(ppc_pkg::OFS_DATA1, 32'h0000_0000, "data1 reset");
		rd_chk(ppc_pkg::OFS_CTRL0, 32'h0000_0000, "ctrl0 reset");
		axi_rd(8'h10, rd_d, rd_r);
		check(32'(rd_r), 32'h3, "unmapped read resp");
		axi_wr(8'h14, 32'h1234_5678, rd_r);
		check(32'(rd_r), 32'h3, "unmapped write resp");
		$display("test reset done");
	endtask

	// Threshold mode across the wrap, so the overflow bit takes part in the compare
	task automatic t_overflow();
		wr(ppc_pkg::OFS_IRQ_MASK, 32'h1);
		wr(ppc_pkg::OFS_CMP0, 32'h7fff_ffff);
		wr(ppc_pkg::OFS_DATA0, 32'h7fff_fffe);
		wr(ppc_pkg::OFS_CTRL0, 32'h0040_0001);
		ev(2'b01, 3);
		rd_chk(ppc_pkg::OFS_DATA0, 32'h8000_0001, "wrap sets overflow");
		check(32'(irq), 32'h1, "irq on overflow");
		rd_chk(ppc_pkg::OFS_IRQ_STS, 32'h3, "irq status");
		rd_chk(ppc_pkg::OFS_IRQ_STS, 32'h0, "irq status cleared");
		check(32'(irq), 32'h0, "irq dropped");
		wr(ppc_pkg::OFS_CTRL0, 32'h0040_1001);
		rd_chk(ppc_pkg::OFS_DATA0, 32'h0000_0001, "overflow clear keeps count");
		rd_chk(ppc_pkg::OFS_CTRL0, 32'h0040_2001, "overflow status gone");
		wr(ppc_pkg::OFS_CTRL0, 32'h0000_2000);
		rd_chk(ppc_pkg::OFS_CTRL0, 32'h0000_0000, "compare status cleared");
		$display("test overflow done");
	endtask

	task automatic t_thresh();
		wr(ppc_pkg::OFS_CMP1, 32'h2);
		wr(ppc_pkg::OFS_CTRL1, 32'h0040_c001);
		ev(2'b10, 2);
		check(32'({glob_sts, pins_out}), 32'h0, "equal is not greater");
		ev(2'b10, 1);
		check(32'({glob_sts, pins_out}), 32'ha, "threshold status out");
		check(32'(irq), 32'h0, "masked irq stays low");
		rd_chk(ppc_pkg::OFS_IRQ_STS, 32'h8, "threshold irq status");
		rd_chk(ppc_pkg::OFS_CTRL1, 32'h0040_e001, "compare status bit");
		wr(ppc_pkg::OFS_CTRL1, 32'h0040_e001);
		rd_chk(ppc_pkg::OFS_CTRL1, 32'h0040_c001, "compare status cleared");
		check(32'(glob_sts), 32'h0, "global status cleared");
		wr(ppc_pkg::OFS_CTRL1, 32'h0);
		$display("test threshold done");
	endtask

	task automatic t_capture();
		wr(ppc_pkg::OFS_CMP0, 32'h1);
		wr(ppc_pkg::OFS_DATA0, 32'h0);
		wr(ppc_pkg::OFS_CTRL0, 32'h0080_0001);
		ev(2'b01, 5);
		rd_chk(ppc_pkg::OFS_CMP0, 32'h5, "capture tracks maximum");
		rd_chk(ppc_pkg::OFS_CTRL0, 32'h0080_0001, "capture leaves status");
		wr(ppc_pkg::OFS_CTRL0, 32'h0);
		$display("test capture done");
	endtask

	task automatic t_sample();
		wr(ppc_pkg::OFS_DATA1, 32'ha);
		sample_start <= 1'b1;
		@(posedge clk);
		sample_start <= 1'b0;
		@(posedge clk);
		rd_chk(ppc_pkg::OFS_DATA1, 32'ha, "preload survives sample");
		// Preload was used up by the first sample, so this one zeroes
		sample_start <= 1'b1;
		@(posedge clk);
		sample_start <= 1'b0;
		@(posedge clk);
		rd_chk(ppc_pkg::OFS_DATA1, 32'h0, "sample start zeroes");
		$display("test sample done");
	endtask

	task automatic t_addr();
		wr(ppc_pkg::OFS_DATA0, 32'h0);
		wr(ppc_pkg::OFS_CMP0, 32'h100);
		wr(ppc_pkg::OFS_CMP1, 32'h200);
		wr(ppc_pkg::OFS_CTRL0, 32'h00c0_0001);
		wr(ppc_pkg::OFS_CTRL1, 32'h00c0_0001);
		addr_valid <= 1'b1;
		req_addr <= 32'h180;
		ev(2'b11, 2);
		req_addr <= 32'h100;
		ev(2'b11, 1);
		req_addr <= 32'h200;
		ev(2'b11, 1);
		req_addr <= 32'h201;
		ev(2'b11, 1);
		addr_valid <= 1'b0;
		rd_chk(ppc_pkg::OFS_DATA0, 32'h3, "range qualifies counter 0");
		rd_chk(ppc_pkg::OFS_DATA1, 32'h3, "range qualifies counter 1");
		wr(ppc_pkg::OFS_CTRL0, 32'h0);
		$display("test address done");
	endtask

	task automatic t_rsel();
		wr(ppc_pkg::OFS_CTRL1, 32'h0020_0001);
		ev(2'b10, 2);
		pins_in <= 4'h1;
		@(posedge clk);
		pins_in <= 4'h0;
		@(posedge clk);
		rd_chk(ppc_pkg::OFS_DATA1, 32'h0, "pin 0 resets count");
		ev(2'b10, 2);
		wr(ppc_pkg::OFS_CTRL1, 32'h0018_0001);
		pins_in <= 4'hf;
		@(posedge clk);
		pins_in <= 4'h0;
		@(posedge clk);
		rd_chk(ppc_pkg::OFS_DATA1, 32'h2, "reserved code no reset");
		$display("test reset select done");
	endtask

	// Partner-driven resets: qualified match, then a rising status edge
	task automatic t_partner();
		wr(ppc_pkg::OFS_CTRL0, 32'h0010_0001);
		ev(2'b01, 3);
		ev(2'b10, 1);
		rd_chk(ppc_pkg::OFS_DATA0, 32'h0, "partner match resets");
		wr(ppc_pkg::OFS_CTRL0, 32'h0008_0001);
		wr(ppc_pkg::OFS_CMP1, 32'h3);
		wr(ppc_pkg::OFS_CTRL1, 32'h0040_0001);
		ev(2'b01, 2);
		ev(2'b10, 1);
		rd_chk(ppc_pkg::OFS_DATA0, 32'h0, "partner status resets");
		// Status stays set, yet only its rising edge may reset again
		ev(2'b01, 2);
		rd_chk(ppc_pkg::OFS_DATA0, 32'h2, "held status resets once");
		wr(ppc_pkg::OFS_CTRL0, 32'h0);
		wr(ppc_pkg::OFS_CTRL1, 32'h0000_2000);
		$display("test partner done");
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		#500000;
		error_cnt++;
		wrap_up();
	end

	// Main sequence
	initial begin
		error_cnt = 0;
		comparisons = 0;
		rst_n = 1'b0;
		{s_awaddr, s_awvalid, s_wdata, s_wvalid, s_araddr, s_arvalid} = '0;
		{ev_in, addr_valid, req_addr, sample_start, pins_in} = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_overflow();
		t_thresh();
		t_capture();
		t_sample();
		t_addr();
		t_rsel();
		t_partner();
		wrap_up();
	end
endmodule // port_perf_counter_pair_bench
